/* alt_consts.svh */
`ifndef ALT_CONSTS_SVH
`define ALT_CONSTS_SVH

// Register offsets
`define ALT_ADDR_CFG       8'h01
`define ALT_ADDR_INT_STAT  8'h02
`define ALT_ADDR_CMP_STAT  8'h30
`define ALT_ADDR_CFG_S1    8'h31
`define ALT_ADDR_CFG_S2    8'h32
`define ALT_ADDR_LVL_FIRST 8'h33
`define ALT_ADDR_LVL_LAST  8'h3a
`define ALT_ADDR_ADC1_LO   8'h3b
`define ALT_ADDR_ADC1_HI   8'h3c
`define ALT_ADDR_ADC2_LO   8'h3d
`define ALT_ADDR_ADC2_HI   8'h3e

// Sensor configuration fields
`define ALT_CFG_LOW_EN_BIT   0
`define ALT_CFG_DARK_EN_BIT  1
`define ALT_CFG_FILT_LSB     2
`define ALT_CFG_FILT_MSB     4
`define ALT_CFG_FORCE_BIT    5
`define ALT_CFG_S1_MASK      8'h3f
`define ALT_CFG_S2_MASK      8'h1f

// Comparator interrupt flag and enable positions (0x02 and 0x01)
`define ALT_INT_S1_BIT       5
`define ALT_INT_S2_BIT       6

// Reset values
`define ALT_RESET_BYTE       8'h00

// Scaling of trip codes to ADC codes (ADC LSB is 0.5 uA)
`define ALT_LOW_SCALE_SHIFT  3

// Conversion timing
`define ALT_CONV_TIME_MS     80
`define ALT_CLK_MHZ          200
`define ALT_CONV_CYCLES      (`ALT_CONV_TIME_MS * 1000 * `ALT_CLK_MHZ)

`endif

/* alt_pkg.sv */
package alt_pkg;

    // Decoded light mode, one-hot
    typedef enum logic [2:0] {
        ALT_MODE_OUTDOOR = 3'h1,
        ALT_MODE_OFFICE  = 3'h2,
        ALT_MODE_DARK    = 3'h4
    } alt_mode_t;

    // Conversion sequencer states, one-hot
    typedef enum logic [1:0] {
        ALT_ST_IDLE = 2'h1,
        ALT_ST_CONV = 2'h2
    } alt_state_t;

    // Per-sensor trip and hysteresis codes
    typedef struct packed {
        logic [7:0] low_trip_level;
        logic [7:0] low_trip_hysteresis;
        logic [7:0] dark_trip_level;
        logic [7:0] dark_trip_hysteresis;
    } alt_levels_t;

    // Per-sensor comparator controls
    typedef struct packed {
        logic       low_trip_enable;
        logic       dark_trip_enable;
        logic [2:0] filter;
    } alt_chan_cfg_t;

    // Comparator outputs of one sensor
    typedef struct packed {
        logic dark_trip_status;
        logic low_trip_status;
    } alt_status_t;

endpackage : alt_pkg

/* alt_chan.sv */
`timescale 1ns/1ps
`default_nettype none
`include "alt_consts.svh"

module alt_chan #(
    parameter int ADC_W = 11
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst_sync_b,
    // Controls
    input  wire alt_pkg::alt_chan_cfg_t cfg,
    input  wire alt_pkg::alt_levels_t  levels,
    input  wire logic                  one_shot,
    // Sample
    input  wire logic                  sample_valid,
    input  wire logic [ADC_W-1:0]      sample,
    // Result
    output alt_pkg::alt_status_t       status
);
    import alt_pkg::*;

    alt_status_t status_reg;
    alt_status_t status_next;
    alt_status_t pend_reg;
    alt_status_t cand;
    logic [7:0]  cnt_reg;
    logic [7:0]  cnt_next;
    logic [7:0]  need;
    logic [11:0] lvl;
    logic [11:0] low_set_at;
    logic [11:0] low_clr_at;
    logic [11:0] dark_set_at;
    logic [11:0] dark_clr_at;
    logic        accept;

    // Trip codes scaled into ADC units: low 4 uA steps, dark 0.5 uA steps
    assign lvl         = 12'(sample);
    assign low_set_at  = 12'({4'h0, levels.low_trip_level}) << `ALT_LOW_SCALE_SHIFT;
    assign low_clr_at  = 12'(9'({1'b0, levels.low_trip_level})
                         + 9'({1'b0, levels.low_trip_hysteresis})) << `ALT_LOW_SCALE_SHIFT;
    assign dark_set_at = 12'({4'h0, levels.dark_trip_level});
    assign dark_clr_at = 12'(9'({1'b0, levels.dark_trip_level})
                         + 9'({1'b0, levels.dark_trip_hysteresis}));

    // Hysteresis: set below trip, clear only above trip plus hysteresis
    assign cand.low_trip_status  = cfg.low_trip_enable &&
        (status_reg.low_trip_status ? !(lvl > low_clr_at) : (lvl < low_set_at));
    assign cand.dark_trip_status = cfg.dark_trip_enable &&
        (status_reg.dark_trip_status ? !(lvl > dark_clr_at) : (lvl < dark_set_at));

    // Sequential-reading filter: 1, 2, 4 .. 128 matching readings
    assign need     = one_shot ? 8'h01 : (8'h01 << cfg.filter);
    assign cnt_next = (cand == pend_reg) ? cnt_reg + 8'h01 : 8'h01;
    assign accept   = (cand != status_reg) && (cnt_next >= need);

    // Disabling a comparator drops its status at once, no filtering
    always_comb
    begin
        status_next = status_reg;
        if (sample_valid && accept)
        begin
            status_next = cand;
        end
        if (!cfg.low_trip_enable)
        begin
            status_next.low_trip_status = 1'b0;
        end
        if (!cfg.dark_trip_enable)
        begin
            status_next.dark_trip_status = 1'b0;
        end
    end

    // Status and filter state
    always_ff @(posedge clk_sys or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            status_reg <= '0;
            pend_reg   <= '0;
            cnt_reg    <= 8'h00;
        end
        else
        begin
            status_reg <= status_next;
            if (sample_valid)
            begin
                pend_reg <= cand;
                cnt_reg  <= (cand == status_reg || accept) ? 8'h00 : cnt_next;
            end
        end
    end

    assign status = status_reg;

endmodule : alt_chan

`default_nettype wire

/* alt_trip_comparators.sv */
`timescale 1ns/1ps
`default_nettype none
`include "alt_consts.svh"

// How it works
// - Low status sets below trip, clears above hysteresis
// - Dark status sets below trip, clears above hysteresis
// - Low comparator enable is bit 0 per sensor
// - Enables independent; converter idles unless one set or force-read set
// - Status pair decodes outdoor, office or dark
// - Force-read bit requests exactly one measurement
// - Sequencer clears force-read bit when measurement ends
// - One conversion takes 80 ms
// - Filter field sets sequential readings, 80ms-10.24s
// - Mode change sets comparator interrupt flag
// - Enabled flag drives interrupt pin active
// - Flag clears only by writing one
// - Trip and hysteresis codes at 0x33-0x3A
// - Register 0x30 reports comparator status
// - ADC results readable at 0x3B-0x3E
module alt_trip_comparators #(
    parameter int ADC_W       = 11,
    parameter int CONV_CYCLES = `ALT_CONV_CYCLES
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    // Register port
    input  wire logic [7:0]       reg_addr,
    input  wire logic             reg_wr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata,
    // Photosensor ADC levels
    input  wire logic [ADC_W-1:0] adc_level_s1,
    input  wire logic [ADC_W-1:0] adc_level_s2,
    // Interrupt pin, active low
    output logic                  int_b,
    output logic                  conv_active
);
    import alt_pkg::*;

    // Mode decode, shared by both sensors
    function automatic alt_mode_t decode_mode(input alt_status_t st);
        if (st.dark_trip_status)
        begin
            decode_mode = ALT_MODE_DARK;
        end
        else if (st.low_trip_status)
        begin
            decode_mode = ALT_MODE_OFFICE;
        end
        else
        begin
            decode_mode = ALT_MODE_OUTDOOR;
        end
    endfunction : decode_mode

    logic             rst_meta_reg;
    logic             rst_sync_b;
    logic [7:0]       cfg_reg;
    logic [7:0]       int_reg;
    logic [7:0]       int_next;
    logic [7:0]       int_set;
    logic [7:0]       cfg_s1_reg;
    logic [7:0]       cfg_s1_next;
    logic [7:0]       cfg_s2_reg;
    logic [7:0]       lvl_reg [0:7];
    logic [ADC_W-1:0] adc1_reg;
    logic [ADC_W-1:0] adc2_reg;
    logic [31:0]      timer_reg;
    alt_state_t       state_reg;
    alt_state_t       state_next;
    alt_mode_t        mode1_reg;
    alt_mode_t        mode2_reg;
    alt_status_t      st1;
    alt_status_t      st2;
    alt_levels_t      lv1;
    alt_levels_t      lv2;
    alt_chan_cfg_t    ch1_cfg;
    alt_chan_cfg_t    ch2_cfg;
    logic [7:0]       rd_mux;
    logic [7:0]       adc1_wide;
    logic [7:0]       adc2_wide;
    logic [7:0]       lvl_idx;
    logic             wr_cfg;
    logic             wr_int;
    logic             wr_s1;
    logic             wr_s2;
    logic             wr_lvl;
    logic             force_rd;
    logic             run_cont;
    logic             conv_done;

    // Reset release through two flops
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_b   <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_b   <= rst_meta_reg;
        end
    end

    // Write decode
    assign lvl_idx = reg_addr - `ALT_ADDR_LVL_FIRST;
    assign wr_cfg  = reg_wr && (reg_addr == `ALT_ADDR_CFG);
    assign wr_int  = reg_wr && (reg_addr == `ALT_ADDR_INT_STAT);
    assign wr_s1   = reg_wr && (reg_addr == `ALT_ADDR_CFG_S1);
    assign wr_s2   = reg_wr && (reg_addr == `ALT_ADDR_CFG_S2);
    assign wr_lvl  = reg_wr && (reg_addr >= `ALT_ADDR_LVL_FIRST)
                     && (reg_addr <= `ALT_ADDR_LVL_LAST);

    // Controls taken from the configuration registers
    assign force_rd = cfg_s1_reg[`ALT_CFG_FORCE_BIT];
    assign ch1_cfg  = '{low_trip_enable:  cfg_s1_reg[`ALT_CFG_LOW_EN_BIT],
                        dark_trip_enable: cfg_s1_reg[`ALT_CFG_DARK_EN_BIT],
                        filter: cfg_s1_reg[`ALT_CFG_FILT_MSB:`ALT_CFG_FILT_LSB]};
    assign ch2_cfg  = '{low_trip_enable:  cfg_s2_reg[`ALT_CFG_LOW_EN_BIT],
                        dark_trip_enable: cfg_s2_reg[`ALT_CFG_DARK_EN_BIT],
                        filter: cfg_s2_reg[`ALT_CFG_FILT_MSB:`ALT_CFG_FILT_LSB]};
    assign run_cont = ch1_cfg.low_trip_enable || ch1_cfg.dark_trip_enable
                      || ch2_cfg.low_trip_enable || ch2_cfg.dark_trip_enable;
    assign lv1 = {lvl_reg[0], lvl_reg[1], lvl_reg[2], lvl_reg[3]};
    assign lv2 = {lvl_reg[4], lvl_reg[5], lvl_reg[6], lvl_reg[7]};

    // Conversion sequencer: idle, or one 80 ms conversion after another
    assign conv_done = (state_reg == ALT_ST_CONV)
                       && (timer_reg == 32'(CONV_CYCLES - 1));
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ALT_ST_IDLE:
            begin
                if (run_cont || force_rd)
                begin
                    state_next = ALT_ST_CONV;
                end
            end
            ALT_ST_CONV:
            begin
                if (conv_done && !run_cont)
                begin
                    state_next = ALT_ST_IDLE;
                end
            end
            default:
            begin
                state_next = ALT_ST_IDLE;
            end
        endcase
    end

    // Force-read clears at conversion end; a fresh write of one wins
    always_comb
    begin
        cfg_s1_next = cfg_s1_reg;
        if (conv_done && force_rd)
        begin
            cfg_s1_next[`ALT_CFG_FORCE_BIT] = 1'b0;
        end
        if (wr_s1)
        begin
            cfg_s1_next = reg_wdata & `ALT_CFG_S1_MASK;
        end
    end

    // Comparator interrupt: set on mode change, clear by writing one
    assign int_set  = {1'b0,
                       (decode_mode(st2) != mode2_reg),
                       (decode_mode(st1) != mode1_reg),
                       5'h00};
    assign int_next = (int_reg & ~(wr_int ? reg_wdata : 8'h00)) | int_set;

    // Read mux; unused bits and unmapped offsets read zero
    assign adc1_wide = 8'(adc1_reg >> 8);
    assign adc2_wide = 8'(adc2_reg >> 8);
    always_comb
    begin
        if (reg_addr == `ALT_ADDR_CFG)
            rd_mux = cfg_reg;
        else if (reg_addr == `ALT_ADDR_INT_STAT)
            rd_mux = int_reg;
        else if (reg_addr == `ALT_ADDR_CMP_STAT)
            rd_mux = {4'h0, st2, st1};
        else if (reg_addr == `ALT_ADDR_CFG_S1)
            rd_mux = cfg_s1_reg;
        else if (reg_addr == `ALT_ADDR_CFG_S2)
            rd_mux = cfg_s2_reg;
        else if (wr_lvl || ((reg_addr >= `ALT_ADDR_LVL_FIRST)
                 && (reg_addr <= `ALT_ADDR_LVL_LAST)))
            rd_mux = lvl_reg[lvl_idx[2:0]];
        else if (reg_addr == `ALT_ADDR_ADC1_LO)
            rd_mux = adc1_reg[7:0];
        else if (reg_addr == `ALT_ADDR_ADC1_HI)
            rd_mux = adc1_wide;
        else if (reg_addr == `ALT_ADDR_ADC2_LO)
            rd_mux = adc2_reg[7:0];
        else if (reg_addr == `ALT_ADDR_ADC2_HI)
            rd_mux = adc2_wide;
        else
            rd_mux = 8'h00;
    end

    // Comparator channels, one per sensor
    alt_chan #(.ADC_W(ADC_W)) u_chan1 (
        .clk_sys      (clk_sys),
        .rst_sync_b   (rst_sync_b),
        .cfg          (ch1_cfg),
        .levels       (lv1),
        .one_shot     (force_rd),
        .sample_valid (conv_done),
        .sample       (adc_level_s1),
        .status       (st1)
    );
    alt_chan #(.ADC_W(ADC_W)) u_chan2 (
        .clk_sys      (clk_sys),
        .rst_sync_b   (rst_sync_b),
        .cfg          (ch2_cfg),
        .levels       (lv2),
        .one_shot     (force_rd),
        .sample_valid (conv_done),
        .sample       (adc_level_s2),
        .status       (st2)
    );

    // Sequencer, timer and captured ADC results
    always_ff @(posedge clk_sys or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            state_reg <= ALT_ST_IDLE;
            timer_reg <= 32'h0;
            adc1_reg  <= '0;
            adc2_reg  <= '0;
        end
        else
        begin
            state_reg <= state_next;
            timer_reg <= (state_reg != ALT_ST_CONV || conv_done) ? 32'h0 : timer_reg + 32'h1;
            if (conv_done)
            begin
                adc1_reg <= adc_level_s1;
                adc2_reg <= adc_level_s2;
            end
        end
    end

    // Software registers and interrupt state
    always_ff @(posedge clk_sys or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            cfg_reg    <= `ALT_RESET_BYTE;
            int_reg    <= `ALT_RESET_BYTE;
            cfg_s1_reg <= `ALT_RESET_BYTE;
            cfg_s2_reg <= `ALT_RESET_BYTE;
            mode1_reg  <= ALT_MODE_OUTDOOR;
            mode2_reg  <= ALT_MODE_OUTDOOR;
            for (int i = 0; i < 8; i++)
                lvl_reg[i] <= `ALT_RESET_BYTE;
        end
        else
        begin
            cfg_reg    <= wr_cfg ? (reg_wdata & 8'h60) : cfg_reg;
            int_reg    <= int_next;
            cfg_s1_reg <= cfg_s1_next;
            cfg_s2_reg <= wr_s2 ? (reg_wdata & `ALT_CFG_S2_MASK) : cfg_s2_reg;
            mode1_reg  <= decode_mode(st1);
            mode2_reg  <= decode_mode(st2);
            if (wr_lvl)
                lvl_reg[lvl_idx[2:0]] <= reg_wdata;
        end
    end

    // Registered outputs; pin pulls low while an enabled flag stands
    always_ff @(posedge clk_sys or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            reg_rdata   <= 8'h00;
            int_b       <= 1'b1;
            conv_active <= 1'b0;
        end
        else
        begin
            reg_rdata   <= reg_rd ? rd_mux : reg_rdata;
            int_b       <= ~|(int_next & cfg_reg);
            conv_active <= (state_next == ALT_ST_CONV);
        end
    end

endmodule : alt_trip_comparators

`default_nettype wire

/* alt_trip_comparators_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module alt_mon #(
    parameter int ADC_W       = 11,
    parameter int CONV_CYCLES = 20
) (
    // Clock and reset
    input wire logic             clk_sys,
    input wire logic             rst_b,
    // Register port
    input wire logic [7:0]       reg_addr,
    input wire logic             reg_wr,
    input wire logic [7:0]       reg_wdata,
    input wire logic             reg_rd,
    input wire logic [7:0]       reg_rdata,
    // Sensor levels and outputs
    input wire logic [ADC_W-1:0] adc_level_s1,
    input wire logic [ADC_W-1:0] adc_level_s2,
    input wire logic             int_b,
    input wire logic             conv_active
);
    logic [7:0] cfg2_reg;
    logic [1:0] en1_reg;
    logic [7:0] lvl_reg [8];
    logic [1:0] quiet_reg;
    logic [2:0] lvl_idx;
    logic       is_lvl;
    logic       mapped;

    // Address decode of what software touches
    assign lvl_idx = 3'(reg_addr - 8'h33);
    assign is_lvl  = reg_addr >= 8'h33 && reg_addr <= 8'h3a;
    assign mapped  = reg_addr == 8'h01 || reg_addr == 8'h02 || (reg_addr >= 8'h30 && is_lvl)
                     || (reg_addr >= 8'h30 && reg_addr <= 8'h3e);

    // Shadow of written values; quiet counts edges since a config write
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg2_reg  <= 8'h00;
            en1_reg   <= 2'h0;
            lvl_reg   <= '{default: 8'h00};
            quiet_reg <= 2'h0;
        end
        else
        begin
            if (reg_wr && reg_addr == 8'h32)
                cfg2_reg <= reg_wdata & 8'h1f;
            if (reg_wr && reg_addr == 8'h31)
                en1_reg <= reg_wdata[1:0];
            if (reg_wr && is_lvl)
                lvl_reg[lvl_idx] <= reg_wdata;
            if (reg_wr && (reg_addr == 8'h31 || reg_addr == 8'h32))
                quiet_reg <= 2'h0;
            else if (quiet_reg != 2'h3)
                quiet_reg <= quiet_reg + 2'h1;
        end
    end

    logic [31:0] run_cnt;

    // Length of the current run of conversions; a run is whole conversions only
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            run_cnt <= 32'h0;
        else
            run_cnt <= conv_active ? run_cnt + 32'h1 : 32'h0;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_conv_start: assert property (
        reg_wr && reg_addr == 8'h31 && reg_wdata[0] ##1 !reg_wr |-> ##[1:2] conv_active)
        else $error("enable did not start conversion");
    a_conv_min: assert property ($rose(conv_active) |-> conv_active [*8])
        else $error("conversion cut short");
    a_conv_len: assert property (
        $fell(conv_active) |-> (run_cnt % CONV_CYCLES) == 32'h0)
        else $error("conversion run not a whole number of conversions");
    a_int_masked: assert property (
        reg_wr && reg_addr == 8'h01 && reg_wdata[6:5] == 2'h0 ##1 !reg_wr |=> ##1 int_b)
        else $error("masked interrupt still drives pin");
    a_cfg2_back: assert property (
        reg_rd && reg_addr == 8'h32 && !reg_wr |=> reg_rdata == $past(cfg2_reg))
        else $error("sensor two config readback wrong");
    a_lvl_back: assert property (
        reg_rd && is_lvl && !reg_wr |=> reg_rdata == $past(lvl_reg[lvl_idx]))
        else $error("level readback wrong");
    a_status_gated: assert property (
        reg_rd && reg_addr == 8'h30 && quiet_reg == 2'h3
        |=> (reg_rdata[3:0] & ~$past({cfg2_reg[1:0], en1_reg})) == 4'h0)
        else $error("status set on disabled comparator");

    c_int_low: cover property ($fell(int_b));
    c_shot_end: cover property ($fell(conv_active));
    c_status_rd: cover property (reg_rd && reg_addr == 8'h30 ##1 reg_rdata != 8'h00);
endmodule : alt_mon

bind alt_trip_comparators alt_mon #(.ADC_W(ADC_W), .CONV_CYCLES(CONV_CYCLES)) u_mon (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .adc_level_s1(adc_level_s1),
    .adc_level_s2(adc_level_s2),
    .int_b(int_b),
    .conv_active(conv_active)
);
`default_nettype wire

/* alt_photo_model.sv */
`timescale 1ns/1ps
`default_nettype none
module alt_photo_model (
    // Clock
    input  wire logic        clk_sys,
    // Light falling on each sensor
    input  wire logic [10:0] light_s1,
    input  wire logic [10:0] light_s2,
    // Converted photocurrent
    output logic      [10:0] adc_level_s1,
    output logic      [10:0] adc_level_s2
);
    // Photocurrent settles one clock after the light moves
    always_ff @(posedge clk_sys)
    begin
        adc_level_s1 <= light_s1;
        adc_level_s2 <= light_s2;
    end
endmodule : alt_photo_model
`default_nettype wire

/* alt_trip_comparators_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module alt_trip_comparators_tb_top;
    localparam int CONV = 20;
    logic        clk_sys;
    logic        rst_b;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic [7:0]  reg_wdata;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [10:0] adc_s1;
    logic [10:0] adc_s2;
    logic [10:0] light_s1;
    logic [10:0] light_s2;
    logic        int_b;
    logic        conv_active;
    logic [7:0]  lvl [8];
    logic [3:0]  st;
    logic [31:0] r;
    int          error_cnt;
    int          n_checks;
    int          seed;
    int          n;

    alt_photo_model u_photo (
        .clk_sys(clk_sys),
        .light_s1(light_s1),
        .light_s2(light_s2),
        .adc_level_s1(adc_s1),
        .adc_level_s2(adc_s2)
    );

    alt_trip_comparators #(.ADC_W(11), .CONV_CYCLES(CONV)) dut (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .adc_level_s1(adc_s1),
        .adc_level_s2(adc_s2),
        .int_b(int_b),
        .conv_active(conv_active)
    );

    // Free-running system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Idle cycle after each access keeps strobes from toggling twice at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        @(negedge clk_sys);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        chk(reg_rdata, e);
        @(negedge clk_sys);
    endtask : rchk

    // Hysteresis comparator: set below trip, clear above trip plus hysteresis
    function automatic logic hys(input logic s, input int lv, input int t, input int h);
        return (lv < t) ? 1'b1 : (lv > t + h) ? 1'b0 : s;
    endfunction : hys

    function automatic int mode(input logic lo, input logic dk);
        return dk ? 2 : lo ? 1 : 0;
    endfunction : mode

    task automatic step(input logic [10:0] l1, input logic [10:0] l2, input int w);
        logic [3:0] nx;
        logic [7:0] fl;
        light_s1 = l1;
        light_s2 = l2;
        repeat (w) @(negedge clk_sys);
        nx[0] = hys(st[0], l1, lvl[0] * 8, lvl[1] * 8);
        nx[1] = hys(st[1], l1, lvl[2], lvl[3]);
        nx[2] = hys(st[2], l2, lvl[4] * 8, lvl[5] * 8);
        nx[3] = hys(st[3], l2, lvl[6], lvl[7]);
        fl    = 8'h00;
        fl[5] = mode(st[0], st[1]) != mode(nx[0], nx[1]);
        fl[6] = mode(st[2], st[3]) != mode(nx[2], nx[3]);
        st    = nx;
        rchk(8'h30, {4'h0, st});
        rchk(8'h3d, l2[7:0]);
        rchk(8'h3e, {5'h0, l2[10:8]});
        rchk(8'h02, fl);
        chk({7'h0, int_b}, {7'h0, fl == 8'h00});
        wr(8'h02, 8'h00);
        rchk(8'h02, fl);
        wr(8'h02, 8'h60);
        rchk(8'h02, 8'h00);
        chk({7'h0, int_b}, 8'h01);
    endtask : step

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        close_out();
    end

    initial
    begin
        seed      = 57;
        error_cnt = 0;
        n_checks  = 0;
        st        = 4'h0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        light_s1  = 11'h200;
        light_s2  = 11'h200;
        rst_b     = 1'b0;
        repeat (20) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (3) @(negedge clk_sys);
        chk({7'h0, conv_active}, 8'h00);
        // Random trip codes, odd so no trip sits at zero
        for (int i = 0; i < 8; i++)
        begin
            lvl[i] = 8'($random(seed)) | 8'h01;
            wr(8'h33 + 8'(i), lvl[i]);
        end
        for (int i = 0; i < 8; i++)
            rchk(8'h33 + 8'(i), lvl[i]);
        wr(8'h20, 8'h5a);
        rchk(8'h20, 8'h00);
        wr(8'h32, 8'hfc);
        rchk(8'h32, 8'h1c);
        // Single shot with both comparators off
        light_s1 = 11'h5a5;
        wr(8'h31, 8'h20);
        n = 0;
        for (int i = 0; i < 4 * CONV && (n == 0 || conv_active); i++)
        begin
            n += int'(conv_active);
            @(negedge clk_sys);
        end
        chk(8'(n), 8'(CONV));
        repeat (2 * CONV) @(negedge clk_sys);
        chk({7'h0, conv_active}, 8'h00);
        rchk(8'h31, 8'h00);
        rchk(8'h3b, 8'ha5);
        rchk(8'h3c, 8'h05);
        rchk(8'h30, 8'h00);
        // Continuous conversion, random and boundary levels
        wr(8'h01, 8'h60);
        rchk(8'h01, 8'h60);
        wr(8'h31, 8'h03);
        wr(8'h32, 8'h03);
        for (int i = 0; i < 12; i++)
        begin
            r = $random(seed);
            if (i % 2)
                step(r[10:0], r[26:16], 2 * CONV + 6);
            else
                step({3'h0, r[7:0]}, {3'h0, r[23:16]}, 2 * CONV + 6);
        end
        step(11'(lvl[0] * 8 - 1), 11'(lvl[6] - 1), 2 * CONV + 6);
        step(11'((lvl[0] + lvl[1]) * 8), 11'(lvl[6] + lvl[7]), 2 * CONV + 6);
        step(11'((lvl[0] + lvl[1]) * 8 + 1), 11'(lvl[6] + lvl[7] + 1), 2 * CONV + 6);
        step(11'(lvl[0] * 8), 11'(lvl[6]), 2 * CONV + 6);
        // Filter of 128 readings holds off the change
        lvl[0] = 8'h10;
        lvl[1] = 8'h04;
        wr(8'h33, lvl[0]);
        wr(8'h34, lvl[1]);
        step(11'h000, light_s2, 2 * CONV + 6);
        wr(8'h31, 8'h1f);
        light_s1 = 11'h7ff;
        repeat (10 * CONV) @(negedge clk_sys);
        rchk(8'h30, {4'h0, st});
        step(11'h7ff, light_s2, 130 * CONV);
        wr(8'h01, 8'h00);
        chk({7'h0, int_b}, 8'h01);
        // Masked mode change: flag still sets, pin must stay high
        wr(8'h31, 8'h03);
        light_s1 = 11'h000;
        repeat (2 * CONV + 6) @(negedge clk_sys);
        rchk(8'h02, 8'h20);
        chk({7'h0, int_b}, 8'h01);
        close_out();
    end
endmodule : alt_trip_comparators_tb_top
`default_nettype wire
